// [src/ckgi2c_port.sv]
// Two-wire target port holding the byte-wide volatile configuration registers.
// Assumes SCL and SDA come from pins; the bench resolves SDA from sda_oe.
// Functional notes
// - Answer only to target id 69h, read/write bit in the LSB.
// - Works at bit rates up to 400 kbit/s.
// - Write: start, id, rw, ack, pointer, ack, data with acks, stop.
// - Sample SDA while SCL high; change SDA only while SCL low.
// - SDA falling with SCL high is a start, beginning a new frame.
// - SDA rising with SCL high is a stop, ending the frame.
// - Write mode: device pulls SDA low in each ninth clock.
// - Single write: pointer byte, one data byte, each acknowledged, then stop.
// - Extra data bytes are acknowledged and stored at incrementing pointer.
// - Read starts like a write but with rw bit set.
// - Pointer holds one past last access; current read uses it.
// - On read id device acknowledges and shifts out one register byte.
// - Repeated start after pointer byte stores nothing, keeps the pointer.
// - Pointer advances after each read byte, acked or not; master ack sends next byte.
// - Pointer wraps from ffh to 00h.
// - Registers take defaults at power-up; written values are volatile.
// - Power-down clears registers unless retention is on.
`timescale 1ns/100ps
module ckgi2c_port #(
    parameter int DEPTH = ckgi2c_pkg::REG_DEPTH
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic power_down,
    input wire logic keep_alive,
    output logic [7:0] pointer_out,
    output logic busy
);
    logic scl_s;
    logic sda_s;
    logic scl_d_r;
    logic sda_d_r;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    ckgi2c_pkg::ckgi2c_state_e state_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic ack_phase_r;
    logic rd_r;
    logic [7:0] register_pointer_r;
    logic [7:0] regs_r [DEPTH];
    logic acked_r;
    logic pd_clear;

    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        ptr_inc = p + 8'h01;
    endfunction

    // Both pins pass four flops before use
    ckgi2c_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .pin(scl),
        .level(scl_s)
    );
    ckgi2c_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .pin(sda_in),
        .level(sda_s)
    );

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (clk_en) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // SDA edges while SCL stays high are frame markers
    assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign pd_clear = power_down && !keep_alive;

    // Bit engine: nine SCL periods per byte, sampled on the rising edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= ckgi2c_pkg::CKGI2C_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'b0;
            rd_r <= 1'b0;
            acked_r <= 1'b0;
        end else if (clk_en) begin
            if (pd_clear) begin
                state_r <= ckgi2c_pkg::CKGI2C_IDLE;
                ack_phase_r <= 1'b0;
            end else if (start_ev) begin
                // A repeated start drops any partial byte, pointer kept
                state_r <= ckgi2c_pkg::CKGI2C_ADDR;
                bit_cnt_r <= 4'h0;
                ack_phase_r <= 1'b0;
            end else if (stop_ev) begin
                state_r <= ckgi2c_pkg::CKGI2C_IDLE;
                ack_phase_r <= 1'b0;
            end else if (scl_rise && !ack_phase_r) begin
                if (state_r == ckgi2c_pkg::CKGI2C_RDATA) begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end else if (state_r != ckgi2c_pkg::CKGI2C_IDLE) begin
                    shift_r <= {shift_r[6:0], sda_s};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
            end else if (scl_rise && ack_phase_r) begin
                acked_r <= !sda_s;
            end else if (scl_fall && !ack_phase_r && bit_cnt_r == 4'h8) begin
                bit_cnt_r <= 4'h0;
                case (state_r)
                    ckgi2c_pkg::CKGI2C_ADDR: begin
                        if (shift_r[7:1] == ckgi2c_pkg::TARGET_ID) begin
                            ack_phase_r <= 1'b1;
                            rd_r <= shift_r[0];
                        end else begin
                            state_r <= ckgi2c_pkg::CKGI2C_SKIP;
                        end
                    end
                    ckgi2c_pkg::CKGI2C_PTR,
                    ckgi2c_pkg::CKGI2C_WDATA,
                    ckgi2c_pkg::CKGI2C_RDATA: ack_phase_r <= 1'b1;
                    default: ack_phase_r <= 1'b0;
                endcase
            end else if (scl_fall && ack_phase_r) begin
                ack_phase_r <= 1'b0;
                case (state_r)
                    ckgi2c_pkg::CKGI2C_ADDR: begin
                        state_r <= rd_r ? ckgi2c_pkg::CKGI2C_RDATA
                            : ckgi2c_pkg::CKGI2C_PTR;
                    end
                    ckgi2c_pkg::CKGI2C_PTR: state_r <= ckgi2c_pkg::CKGI2C_WDATA;
                    ckgi2c_pkg::CKGI2C_RDATA: begin
                        // A nack ends transmission until the next start or stop
                        if (!acked_r) begin
                            state_r <= ckgi2c_pkg::CKGI2C_SKIP;
                        end
                    end
                    default: state_r <= state_r;
                endcase
            end
        end
    end

    // Pointer loads from the pointer byte and advances per byte moved
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            register_pointer_r <= ckgi2c_pkg::PTR_RESET;
        end else if (clk_en) begin
            if (pd_clear) begin
                register_pointer_r <= ckgi2c_pkg::PTR_RESET;
            end else if (scl_fall && !ack_phase_r && bit_cnt_r == 4'h8) begin
                if (state_r == ckgi2c_pkg::CKGI2C_PTR) begin
                    register_pointer_r <= shift_r;
                end else if (state_r == ckgi2c_pkg::CKGI2C_WDATA) begin
                    register_pointer_r <= ptr_inc(register_pointer_r);
                end else if (state_r == ckgi2c_pkg::CKGI2C_RDATA) begin
                    // Advance after each byte sent so pointer is one past last
                    register_pointer_r <= ptr_inc(register_pointer_r);
                end
            end
        end
    end

    // Storage written only on a completed data byte, so an aborted write stores nothing
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                regs_r[i] <= ckgi2c_pkg::REG_DEFAULT;
            end
        end else if (clk_en) begin
            if (pd_clear) begin
                for (int i = 0; i < DEPTH; i++) begin
                    regs_r[i] <= ckgi2c_pkg::REG_DEFAULT;
                end
            end else if (scl_fall && !ack_phase_r && bit_cnt_r == 4'h8
                         && state_r == ckgi2c_pkg::CKGI2C_WDATA) begin
                regs_r[register_pointer_r] <= shift_r;
            end
        end
    end

    // SDA drive: changes on SCL falling edges, released on start, stop or clearing power-down
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else if (clk_en) begin
            sda_out <= 1'b0;
            if (pd_clear || start_ev || stop_ev) begin
                sda_oe <= 1'b0;
            end else if (scl_fall) begin
                if (!ack_phase_r && bit_cnt_r == 4'h8) begin
                    case (state_r)
                        ckgi2c_pkg::CKGI2C_ADDR: begin
                            sda_oe <= (shift_r[7:1] == ckgi2c_pkg::TARGET_ID);
                        end
                        ckgi2c_pkg::CKGI2C_PTR,
                        ckgi2c_pkg::CKGI2C_WDATA: sda_oe <= 1'b1;
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (ack_phase_r) begin
                    // First read bit follows address ack or master ack
                    if ((state_r == ckgi2c_pkg::CKGI2C_ADDR && rd_r) ||
                        (state_r == ckgi2c_pkg::CKGI2C_RDATA && acked_r)) begin
                        sda_oe <= !regs_r[register_pointer_r][7];
                    end else begin
                        sda_oe <= 1'b0;
                    end
                end else if (state_r == ckgi2c_pkg::CKGI2C_RDATA) begin
                    // Open drain: drive low only for zero bits
                    sda_oe <= !regs_r[register_pointer_r][3'd7 - bit_cnt_r[2:0]];
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pointer_out <= ckgi2c_pkg::PTR_RESET;
            busy <= 1'b0;
        end else if (clk_en) begin
            pointer_out <= register_pointer_r;
            busy <= (state_r != ckgi2c_pkg::CKGI2C_IDLE);
        end
    end
endmodule

// [common/ckgi2c_pkg.sv]
// Constants for the clock generator two-wire register port.
// Assumes a 200 MHz system clock sampling the serial pins.
package ckgi2c_pkg;
    localparam logic [6:0] TARGET_ID = 7'h69;
    localparam int CLK_MHZ = 200;
    localparam int MAX_RATE_KBPS = 400;
    localparam int BIT_NS = 1000000 / MAX_RATE_KBPS;
    localparam int BIT_CYCLES = BIT_NS * CLK_MHZ / 1000;
    localparam int TDH_NS = 0;
    localparam int TDH_CYCLES = (TDH_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (TDH_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] REG_DEFAULT = 8'h00;
    localparam int REG_DEPTH = 256;
    typedef enum logic [2:0] {
        CKGI2C_IDLE = 3'b000,
        CKGI2C_ADDR = 3'b001,
        CKGI2C_PTR = 3'b010,
        CKGI2C_WDATA = 3'b011,
        CKGI2C_RDATA = 3'b100,
        CKGI2C_SKIP = 3'b101
    } ckgi2c_state_e;
endpackage

// [src/ckgi2c_sync.sv]
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/100ps
module ckgi2c_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic pin,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Level only moves when stages two and three agree
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_r <= RESET_LEVEL;
            s2_r <= RESET_LEVEL;
            s3_r <= RESET_LEVEL;
            level <= RESET_LEVEL;
        end else if (clk_en) begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level <= s3_r;
            end
        end
    end
endmodule

// [test/ckgi2c_port_sva.sv]
// Pin checker for the two-wire register port.
// Assumes one clock domain; bound onto every ckgi2c_port.
`timescale 1ns/100ps
module ckgi2c_port_sva (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_down,
    input wire logic keep_alive,
    input wire logic [7:0] pointer_out,
    input wire logic busy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    property p_out_zero;
        sda_out == 1'b0;
    endproperty
    property p_oe_busy;
        sda_oe |-> busy;
    endproperty
    // Bit changes must land while the clock is low
    property p_oe_scl_low;
        $changed(sda_oe) |-> !scl;
    endproperty
    property p_fell_busy;
        $fell(busy) |-> !sda_oe;
    endproperty
    property p_busy_scl_high;
        $changed(busy) && !power_down && !$past(power_down) |-> scl;
    endproperty
    property p_oe_hold;
        $rose(sda_oe) |-> sda_oe [*8];
    endproperty
    property p_pd_clear;
        clk_en && power_down && !keep_alive |-> ##[1:4] (pointer_out == 8'h00 && !busy);
    endproperty
    property p_pd_keep;
        power_down && keep_alive |=> $stable(pointer_out);
    endproperty
    a_out_zero: assert property (p_out_zero) else $error("sda_out not low");
    a_oe_busy: assert property (p_oe_busy) else $error("sda driven outside frame");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
    a_fell_busy: assert property (p_fell_busy) else $error("sda held after stop");
    a_busy_scl_high: assert property (p_busy_scl_high) else $error("frame edge, scl low");
    a_oe_hold: assert property (p_oe_hold) else $error("sda low too short");
    a_pd_clear: assert property (p_pd_clear) else $error("power-down kept state");
    a_pd_keep: assert property (p_pd_keep) else $error("retention lost pointer");
    c_frame: cover property ($rose(busy));
    c_drive: cover property ($rose(sda_oe));
    c_pd: cover property (power_down && !keep_alive);
endmodule
bind ckgi2c_port ckgi2c_port_sva ckgi2c_port_sva_i (.clock(clock), .nrst(nrst),
    .clk_en(clk_en), .scl(scl),
    .sda_out(sda_out), .sda_oe(sda_oe), .power_down(power_down), .keep_alive(keep_alive),
    .pointer_out(pointer_out), .busy(busy));

// [test/ckgi2c_master.sv]
// Two-wire bus master model driving scl and its share of sda.
// Assumes sda is the resolved wire with a pull-up.
`timescale 1ns/100ps
module ckgi2c_master (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Low 7, high 6 cycles; sampled late to cover sync latency
    task automatic xb(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            scl <= 1'b0;
            tick(3);
            sda_m <= tx[i];
            tick(4);
            scl <= 1'b1;
            tick(5);
            rx[i] = sda;
            tick(1);
        end
    endtask
    task automatic start(input bit again);
        if (again) begin
            scl <= 1'b0;
            tick(3);
            sda_m <= 1'b1;
            tick(4);
            scl <= 1'b1;
            tick(6);
        end
        sda_m <= 1'b0;
        tick(10);
    endtask
    task automatic stop;
        scl <= 1'b0;
        tick(3);
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(6);
        sda_m <= 1'b1;
        tick(10);
    endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the two-wire register port.
// Assumes the master model and a pull-up on sda.
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
    typedef struct packed {logic [7:0] p; logic [7:0] d; logic [7:0] nxt;} ckgi2c_row_s;
    localparam logic [7:0] WID = {ckgi2c_pkg::TARGET_ID, 1'b0};
    ckgi2c_row_s rows [3] = '{'{8'h00, 8'ha5, 8'h01}, '{8'h7f, 8'h3c, 8'h80},
        '{8'hff, 8'h5a, 8'h00}};
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic power_down = 1'b0;
    logic keep_alive = 1'b0;
    logic clk_en = 1'b1;
    logic scl, sda_m, sda_out, sda_oe, busy;
    logic [7:0] pointer_out;
    logic [8:0] rx;
    int failures = 0;
    int compares = 0;
    wire sda = sda_m & !sda_oe;
    always #2.5 clock = ~clock;
    ckgi2c_master ckgi2c_master_i (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
    ckgi2c_port ckgi2c_port_i (.clock(clock), .nrst(nrst), .clk_en(clk_en), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .power_down(power_down),
        .keep_alive(keep_alive), .pointer_out(pointer_out), .busy(busy));
    task automatic wrap_up;
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n, input bit fin);
        ckgi2c_master_i.start(1'b0);
        ckgi2c_master_i.xb({WID, 1'b1}, rx);
        `CHK("id ack", 1'b0, rx[0])
        ckgi2c_master_i.xb({p, 1'b1}, rx);
        `CHK("ptr ack", 1'b0, rx[0])
        for (int i = 0; i < n; i++) begin
            ckgi2c_master_i.xb({d + 8'(i), 1'b1}, rx);
            `CHK("data ack", 1'b0, rx[0])
        end
        if (fin)
            ckgi2c_master_i.stop();
    endtask
    task automatic rd(input logic [7:0] d, input int n, input bit again);
        ckgi2c_master_i.start(again);
        ckgi2c_master_i.xb({WID | 8'h01, 1'b1}, rx);
        `CHK("rd ack", 1'b0, rx[0])
        for (int i = 0; i < n; i++) begin
            ckgi2c_master_i.xb({8'hff, i == n - 1}, rx);
            `CHK("rd data", d + 8'(i), rx[8:1])
        end
        ckgi2c_master_i.stop();
    endtask
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        ckgi2c_master_i.tick(2);
        `CHK("ptr rst", 8'h00, pointer_out)
        `CHK("busy rst", 1'b0, busy)
        ckgi2c_master_i.tick(10);
        foreach (rows[k]) begin
            wr(rows[k].p, rows[k].d, 1, 1'b1);
            wr(rows[k].p, 8'h00, 0, 1'b0);
            rd(rows[k].d, 1, 1'b1);
            `CHK("ptr", rows[k].nxt, pointer_out)
        end
        wr(8'hfe, 8'h10, 3, 1'b1);
        wr(8'hfe, 8'h00, 0, 1'b0);
        rd(8'h10, 3, 1'b1);
        rd(8'h00, 1, 1'b0);
        ckgi2c_master_i.start(1'b0);
        ckgi2c_master_i.xb({ckgi2c_pkg::TARGET_ID ^ 7'h01, 2'b01}, rx);
        `CHK("bad id", 1'b1, rx[0])
        ckgi2c_master_i.xb({8'h7f, 1'b1}, rx);
        ckgi2c_master_i.xb({8'hee, 1'b1}, rx);
        ckgi2c_master_i.stop();
        wr(8'h7f, 8'h00, 0, 1'b0);
        rd(8'h3c, 1, 1'b1);
        keep_alive <= 1'b1;
        power_down <= 1'b1;
        ckgi2c_master_i.tick(10);
        power_down <= 1'b0;
        keep_alive <= 1'b0;
        ckgi2c_master_i.tick(5);
        wr(8'h7f, 8'h00, 0, 1'b0);
        rd(8'h3c, 1, 1'b1);
        // Frozen block must ignore a clearing power-down
        clk_en <= 1'b0;
        ckgi2c_master_i.tick(2);
        power_down <= 1'b1;
        ckgi2c_master_i.tick(10);
        power_down <= 1'b0;
        ckgi2c_master_i.tick(2);
        `CHK("ptr frz", 8'h80, pointer_out)
        clk_en <= 1'b1;
        ckgi2c_master_i.tick(5);
        wr(8'h7f, 8'h00, 0, 1'b0);
        rd(8'h3c, 1, 1'b1);
        power_down <= 1'b1;
        ckgi2c_master_i.tick(10);
        power_down <= 1'b0;
        ckgi2c_master_i.tick(5);
        `CHK("ptr pd", 8'h00, pointer_out)
        wr(8'h7f, 8'h00, 0, 1'b0);
        rd(8'h00, 1, 1'b1);
        wrap_up();
    end
    initial begin
        #150000;
        failures++;
        wrap_up();
    end
endmodule
